// File: ric_top.sv
// ric_top: image check and check-and-apply command handler with Avalon-MM status
// assumes one request pulse with fields; reply taken on rsp_valid and rsp_ready
// Behaviour
// RULE1: code 05 checks the stored image, 06 checks then applies when valid.
// RULE2: valid apply resets into new image and sends no reply.
// RULE3: requester puts zero in option flags for image commands.
// RULE4: requester zeroes block, offset and count; no payload.
// RULE5: check reply uses code 85; outcome bit 0 is 1 when invalid.
// RULE6: image replies carry zero block, offset, count and no payload.
// RULE7: reply goes to the source endpoint of the request.
// RULE8: apply replies with code 86 only when invalid, outcome bit 0 set.
// RULE9: a memory write only clears bits; only erase sets them.
// RULE10: erase clears a whole block; partial erase is refused.
// RULE11: applying an image wipes the whole general purpose memory.
// RULE12: reserved outcome bits are driven to zero.
//
// Local design decisions: the address map and register access over Avalon-MM.
`timescale 1ns/100ps
module ric_top
   import ric_pkg::*;
#(
   parameter int WORDS = ric_pkg::RIC_MEM_WORDS,
   parameter int BLK   = ric_pkg::RIC_BLK_WORDS
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // request
   input  wire logic        req_valid,
   input  wire logic [7:0]  command_code_field,
   input  wire logic [7:0]  option_flags_field,
   input  wire logic [15:0] block_index_field,
   input  wire logic [15:0] byte_offset_field,
   input  wire logic [15:0] byte_count_field,
   input  wire logic [7:0]  payload_field,
   input  wire logic [7:0]  src_endpoint,
   output logic             req_ready,
   // reply
   output logic             rsp_valid,
   input  wire logic        rsp_ready,
   output logic [7:0]       rsp_command_code,
   output logic [7:0]       rsp_outcome,
   output logic [15:0]      rsp_block_index,
   output logic [15:0]      rsp_byte_offset,
   output logic [15:0]      rsp_byte_count,
   output logic [7:0]       rsp_dest_endpoint,
   // image install
   output logic             image_reset,
   // avalon-mm slave
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   // interrupt
   output logic             irq
);
   typedef struct packed {
      ric_state_type state;
      logic          apply;
      logic          valid_q;
      logic [7:0]    dest;
      logic [7:0]    code;
      logic [7:0]    outcome;
      logic          reset_pulse;
      logic [2:0]    status;
      logic [2:0]    mask;
      logic          ack;
      logic [31:0]   rdata;
   } ric_top_type;
   ric_top_type r, next_r;

   logic [WORDS*8-1:0] mem_flat;
   logic               image_valid;
   logic               wipe;
   logic               do_erase;
   logic               do_write;
   logic               accept;
   logic               take_image;
   logic               refused;

   function automatic logic is_image_cmd(input logic [7:0] code);
      return (code == RIC_CMD_CHECK) || (code == RIC_CMD_APPLY); // [RULE1]
   endfunction : is_image_cmd

   ////////////////////////////////////////////////////////////////////////
   // memory and verdict
   assign req_ready = (r.state == RIC_IDLE);
   assign accept    = req_valid && req_ready;
   assign wipe      = (r.state == RIC_WIPE);
   // partial erase: nonzero offset or count not a whole block is dropped
   assign do_erase  = accept && (command_code_field == RIC_CMD_ERASE)
                      && (byte_offset_field == 16'h0000)
                      && (byte_count_field == 16'(BLK)); // [RULE10]
   assign do_write  = accept && (command_code_field == RIC_CMD_WRITE);
   assign take_image = accept && is_image_cmd(command_code_field); // [RULE1]
   assign refused    = accept && (command_code_field == RIC_CMD_ERASE) && !do_erase; // [RULE10]

   ric_flash #(.WORDS(WORDS), .BLK(BLK)) u_flash (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .wipe      (wipe),
      .erase     (do_erase),
      .erase_blk (block_index_field[7:0]),
      .write     (do_write),
      .wr_addr   (8'(block_index_field[7:0] * 8'(BLK) + byte_offset_field[7:0])),
      .wr_data   (payload_field),
      .mem_flat  (mem_flat)
   );

   ric_validity #(.WORDS(WORDS)) u_valid (
      .mem_flat    (mem_flat),
      .image_valid (image_valid)
   );

   ////////////////////////////////////////////////////////////////////////
   // command sequencer and registers
   always_comb begin
      next_r = r;
      next_r.reset_pulse = 1'b0;
      next_r.ack = 1'b0;
      // read clears first, so an event of this same cycle still sets its bit
      if (r.ack && avs_read && (avs_address == RIC_REG_STATUS)) begin
         next_r.status = 3'h0;
      end
      unique case (r.state)
         RIC_IDLE: begin
            if (accept && is_image_cmd(command_code_field)) begin
               // option and unused fields are the requester's duty; not checked
               next_r.apply = (command_code_field == RIC_CMD_APPLY); // [RULE1]
               next_r.dest  = src_endpoint; // [RULE7]
               next_r.state = RIC_CHECK;
            end
            if (accept && (command_code_field == RIC_CMD_ERASE) && !do_erase) begin
               next_r.status[RIC_IRQ_REJECT_BIT] = 1'b1; // [RULE10]
            end
         end
         RIC_CHECK: begin
            next_r.valid_q = image_valid;
            if (r.apply && image_valid) begin
               next_r.state = RIC_WIPE; // [RULE2]
            end else begin
               next_r.code    = r.apply ? RIC_RSP_APPLY : RIC_RSP_CHECK; // [RULE5] [RULE8]
               next_r.outcome = image_valid ? RIC_OUTCOME_GOOD : RIC_OUTCOME_BAD; // [RULE12]
               next_r.state   = RIC_REPLY;
            end
         end
         RIC_REPLY: begin
            if (rsp_ready) begin
               next_r.state = RIC_IDLE;
               if (r.apply) next_r.status[RIC_IRQ_APPLY_BIT] = 1'b1;
               else next_r.status[RIC_IRQ_CHECK_BIT] = 1'b1;
            end
         end
         RIC_WIPE: begin
            next_r.reset_pulse = 1'b1; // [RULE2] [RULE11]
            next_r.status[RIC_IRQ_APPLY_BIT] = 1'b1;
            next_r.state = RIC_IDLE;
         end
      endcase
      // bus: one wait cycle, answer on the second edge
      if ((avs_read || avs_write) && !r.ack) begin
         next_r.ack = 1'b1;
         next_r.rdata = 32'h0000_0000;
         unique case (avs_address)
            RIC_REG_STATUS:  next_r.rdata = {29'h0, r.status};
            RIC_REG_MASK:    next_r.rdata = {29'h0, r.mask};
            RIC_REG_MEMPEEK: next_r.rdata = {24'h0, mem_flat[7:0]};
            default:         next_r.rdata = 32'h0000_0000;
         endcase
      end
      if (r.ack && avs_write && (avs_address == RIC_REG_MASK)) begin
         next_r.mask = avs_writedata[2:0];
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         r.state       <= RIC_IDLE;
         r.apply       <= 1'b0;
         r.valid_q     <= 1'b0;
         r.dest        <= 8'h00;
         r.code        <= 8'h00;
         r.outcome     <= 8'h00;
         r.reset_pulse <= 1'b0;
         r.status      <= 3'h0;
         r.mask        <= RIC_MASK_RESET;
         r.ack         <= 1'b0;
         r.rdata       <= 32'h0000_0000;
      end else begin
         r <= next_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs
   assign rsp_valid         = (r.state == RIC_REPLY);
   assign rsp_command_code  = r.code;
   assign rsp_outcome       = r.outcome;
   assign rsp_block_index   = 16'h0000; // [RULE6]
   assign rsp_byte_offset   = 16'h0000; // [RULE6]
   assign rsp_byte_count    = 16'h0000; // [RULE6]
   assign rsp_dest_endpoint = r.dest;
   assign image_reset       = r.reset_pulse;
   assign avs_waitrequest   = (avs_read || avs_write) && !r.ack;
   assign avs_readdata      = r.rdata;
   assign irq               = |(r.status & r.mask);

   ////////////////////////////////////////////////////////////////////////
   // checks
   AST_APPLY_NO_REPLY: assert property (@(posedge clk) disable iff (sys_rst) // [RULE2]
      (r.state == RIC_CHECK && r.apply && image_valid) |=> !rsp_valid ##1 image_reset)
      else $error("valid apply must reset without reply");
   AST_CHECK_CODE: assert property (@(posedge clk) disable iff (sys_rst) // [RULE5]
      (rsp_valid && !r.apply) |-> rsp_command_code == 8'h85)
      else $error("check reply code wrong");
   AST_CHECK_OUTCOME: assert property (@(posedge clk) disable iff (sys_rst) // [RULE5]
      (r.state == RIC_CHECK && !r.apply) |=> rsp_outcome[0] == !$past(image_valid))
      else $error("check outcome bit wrong");
   AST_APPLY_BAD: assert property (@(posedge clk) disable iff (sys_rst) // [RULE8]
      (rsp_valid && r.apply) |-> (rsp_command_code == 8'h86 && rsp_outcome == 8'h01))
      else $error("apply reply malformed");
   AST_ZERO_FIELDS: assert property (@(posedge clk) disable iff (sys_rst) // [RULE6]
      rsp_valid |-> (rsp_block_index == 0 && rsp_byte_offset == 0 && rsp_byte_count == 0))
      else $error("reply fields not zero");
   AST_DEST: assert property (@(posedge clk) disable iff (sys_rst) // [RULE7]
      (accept && is_image_cmd(command_code_field)) |=> r.dest == $past(src_endpoint))
      else $error("reply destination not captured");
   AST_RESERVED: assert property (@(posedge clk) disable iff (sys_rst) // [RULE12]
      rsp_valid |-> rsp_outcome[7:1] == 7'h00)
      else $error("reserved outcome bits set");
   AST_WIPE: assert property (@(posedge clk) disable iff (sys_rst) // [RULE11]
      wipe |=> (mem_flat == {WORDS{8'hFF}}))
      else $error("apply did not wipe memory");
   AST_WRITE_CLEARS: assert property (@(posedge clk) disable iff (sys_rst) // [RULE9]
      (do_write && !do_erase && !wipe) |=> ((mem_flat & ~$past(mem_flat)) == '0))
      else $error("write set a bit");
   AST_REPLY_BOUND: assert property (@(posedge clk) disable iff (sys_rst) // [RULE1]
      (accept && is_image_cmd(command_code_field)) |-> ##2 (rsp_valid || image_reset || wipe))
      else $error("image command not answered");

   // sequencing: one image command at a time
   AST_BUSY_NO_TAKE: assert property (@(posedge clk) disable iff (sys_rst) // [RULE1]
      (r.state != RIC_IDLE) |-> !req_ready)
      else $error("request taken while busy");
   AST_TAKE_TO_CHECK: assert property (@(posedge clk) disable iff (sys_rst) // [RULE1]
      take_image |=> (r.state == RIC_CHECK))
      else $error("image command did not start a check");
   AST_APPLY_LATCH: assert property (@(posedge clk) disable iff (sys_rst) // [RULE1]
      take_image |=> (r.apply == $past(command_code_field == RIC_CMD_APPLY)))
      else $error("apply flag not latched from code");
   AST_REPLY_DONE: assert property (@(posedge clk) disable iff (sys_rst) // [RULE1]
      (rsp_valid && rsp_ready) |=> (r.state == RIC_IDLE))
      else $error("reply taken but not back to idle");

   // install path: wipe, one reset pulse, never a reply
   AST_APPLY_TO_WIPE: assert property (@(posedge clk) disable iff (sys_rst) // [RULE2]
      (r.state == RIC_CHECK && r.apply && image_valid) |=> wipe)
      else $error("valid apply did not wipe");
   AST_RESET_ONE: assert property (@(posedge clk) disable iff (sys_rst) // [RULE2]
      image_reset |=> !image_reset)
      else $error("install reset longer than one cycle");
   AST_RESET_SOURCE: assert property (@(posedge clk) disable iff (sys_rst) // [RULE2]
      image_reset |-> $past(wipe))
      else $error("install reset without wipe");
   AST_WIPE_NO_REPLY: assert property (@(posedge clk) disable iff (sys_rst) // [RULE2]
      wipe |-> !rsp_valid)
      else $error("reply shown during install");
   AST_WIPE_STATE: assert property (@(posedge clk) disable iff (sys_rst) // [RULE11]
      wipe |=> (r.state == RIC_IDLE && image_reset))
      else $error("wipe not followed by reset");

   // check and bad apply replies; plain check never installs
   AST_CHECK_GOOD: assert property (@(posedge clk) disable iff (sys_rst) // [RULE5]
      (r.state == RIC_CHECK && !r.apply && image_valid) |=> (rsp_valid && rsp_outcome == 8'h00))
      else $error("good image reported bad");
   AST_CHECK_NO_WIPE: assert property (@(posedge clk) disable iff (sys_rst) // [RULE5]
      (r.state == RIC_CHECK && !r.apply) |=> !wipe ##1 !image_reset)
      else $error("plain check installed an image");
   AST_APPLY_BAD_REPLY: assert property (@(posedge clk) disable iff (sys_rst) // [RULE8]
      (r.state == RIC_CHECK && r.apply && !image_valid)
      |=> (rsp_valid && rsp_command_code == 8'h86 && rsp_outcome[0]))
      else $error("bad apply not reported");
   AST_RESERVED_NEXT: assert property (@(posedge clk) disable iff (sys_rst) // [RULE12]
      (r.state == RIC_CHECK && !(r.apply && image_valid)) |=> (rsp_outcome[7:1] == 7'h00))
      else $error("reserved outcome bits loaded");

   // reply aimed at the requester and unchanged until the consumer takes it
   AST_REPLY_HOLD: assert property (@(posedge clk) disable iff (sys_rst) // [RULE7]
      (rsp_valid && !rsp_ready) |=> (rsp_valid && $stable(rsp_dest_endpoint)
      && $stable(rsp_command_code) && $stable(rsp_outcome)))
      else $error("reply changed before taken");
   AST_DEST_REPLY: assert property (@(posedge clk) disable iff (sys_rst) // [RULE7]
      take_image |-> ##2 (wipe || rsp_dest_endpoint == $past(src_endpoint, 2)))
      else $error("reply not aimed at requester");

   // memory rules
   AST_REFUSE_FLAG: assert property (@(posedge clk) disable iff (sys_rst) // [RULE10]
      refused |=> r.status[RIC_IRQ_REJECT_BIT])
      else $error("partial erase not flagged");
   AST_REFUSE_KEEPS: assert property (@(posedge clk) disable iff (sys_rst) // [RULE10]
      refused |=> (mem_flat == $past(mem_flat)))
      else $error("partial erase changed memory");
   AST_ERASE_SETS: assert property (@(posedge clk) disable iff (sys_rst) // [RULE9]
      do_erase |=> ((~mem_flat & $past(mem_flat)) == '0))
      else $error("erase cleared a bit");
   AST_MEM_QUIET: assert property (@(posedge clk) disable iff (sys_rst) // [RULE9]
      (!do_write && !do_erase && !wipe) |=> (mem_flat == $past(mem_flat)))
      else $error("memory changed with no operation");

   COV_REFUSE: cover property (@(posedge clk) refused);
   COV_CHECK: cover property (@(posedge clk) rsp_valid && rsp_ready && !r.apply);
   COV_APPLY_BAD: cover property (@(posedge clk) rsp_valid && rsp_ready && r.apply);
   COV_APPLY_OK: cover property (@(posedge clk) image_reset);
   COV_IRQ: cover property (@(posedge clk) irq);
endmodule : ric_top

// File: ric_pkg.sv
// ric_pkg: constants and types for the remote image check handler
// assumes a single 125 MHz clock domain
package ric_pkg;
   localparam logic [7:0] RIC_CMD_CHECK       = 8'h05;
   localparam logic [7:0] RIC_CMD_APPLY       = 8'h06;
   localparam logic [7:0] RIC_CMD_ERASE       = 8'h01;
   localparam logic [7:0] RIC_CMD_WRITE       = 8'h02;
   localparam logic [7:0] RIC_RSP_CHECK       = 8'h85;
   localparam logic [7:0] RIC_RSP_APPLY       = 8'h86;
   localparam logic [7:0] RIC_OUTCOME_BAD     = 8'h01;
   localparam logic [7:0] RIC_OUTCOME_GOOD    = 8'h00;
   localparam int         RIC_MEM_WORDS       = 16;
   localparam int         RIC_BLK_WORDS       = 4;
   localparam logic [7:0] RIC_ERASED          = 8'hFF;
   localparam logic [7:0] RIC_IMAGE_TAG       = 8'hA5;
   // register map, byte addresses
   localparam logic [3:0] RIC_REG_STATUS      = 4'h0;
   localparam logic [3:0] RIC_REG_MASK        = 4'h4;
   localparam logic [3:0] RIC_REG_MEMPEEK     = 4'h8;
   localparam logic [1:0] RIC_IRQ_CHECK_BIT   = 2'h0;
   localparam logic [1:0] RIC_IRQ_APPLY_BIT   = 2'h1;
   localparam logic [1:0] RIC_IRQ_REJECT_BIT  = 2'h2;
   localparam logic [2:0] RIC_MASK_RESET      = 3'h0;

   typedef enum logic [1:0] {
      RIC_IDLE  = 2'b00,
      RIC_CHECK = 2'b01,
      RIC_REPLY = 2'b11,
      RIC_WIPE  = 2'b10
   } ric_state_type;
endpackage : ric_pkg

// File: ric_validity.sv
// ric_validity: combinational image validity test over memory contents
// assumes memory is presented flat, word 0 holding the image tag
`timescale 1ns/100ps
module ric_validity
   import ric_pkg::*;
#(
   parameter int WORDS = 16
) (
   // memory view
   input  wire logic [WORDS*8-1:0] mem_flat,
   // verdict
   output logic                    image_valid
);
   logic [7:0] sum;
   always_comb begin
      sum = 8'h00;
      for (int i = 0; i < WORDS; i++) begin
         sum = sum + mem_flat[i*8 +: 8];
      end
      // tag plus zero checksum; erased memory never passes
      image_valid = (mem_flat[7:0] == RIC_IMAGE_TAG) && (sum == 8'h00);
   end
endmodule : ric_validity

// File: ric_flash.sv
// ric_flash: flip-flop model of the general purpose memory
// assumes at most one operation per cycle, priority wipe, erase, write
`timescale 1ns/100ps
module ric_flash
   import ric_pkg::*;
#(
   parameter int WORDS = 16,
   parameter int BLK   = 4
) (
   // clock and reset
   input  wire logic               clk,
   input  wire logic               sys_rst,
   // operations
   input  wire logic               wipe,
   input  wire logic               erase,
   input  wire logic [7:0]         erase_blk,
   input  wire logic               write,
   input  wire logic [7:0]         wr_addr,
   input  wire logic [7:0]         wr_data,
   // contents
   output logic [WORDS*8-1:0]      mem_flat
);
   typedef struct packed {
      logic [WORDS*8-1:0] mem;
   } ric_flash_type;
   ric_flash_type r, next_r;

   always_comb begin
      next_r = r;
      for (int i = 0; i < WORDS; i++) begin
         if (wipe) begin
            next_r.mem[i*8 +: 8] = RIC_ERASED; // [RULE11]
         end else if (erase && ((i / BLK) == int'(erase_blk))) begin
            next_r.mem[i*8 +: 8] = RIC_ERASED; // [RULE10]
         end else if (write && (i == int'(wr_addr))) begin
            next_r.mem[i*8 +: 8] = r.mem[i*8 +: 8] & wr_data; // [RULE9]
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         r <= '{mem: {WORDS{8'hFF}}};
      end else begin
         r <= next_r;
      end
   end
   assign mem_flat = r.mem;
endmodule : ric_flash

// File: ric_node.sv
// ric_node: remote requester model, one image or memory command at a time
// assumes the handler's clock; tb sets stall to slow the reply consumer
`timescale 1ns/100ps
module ric_node (
   // clock
   input  wire logic        clk,
   // request
   output logic             req_valid,
   output logic [7:0]       command_code_field,
   output logic [7:0]       option_flags_field,
   output logic [15:0]      block_index_field,
   output logic [15:0]      byte_offset_field,
   output logic [15:0]      byte_count_field,
   output logic [7:0]       payload_field,
   output logic [7:0]       src_endpoint,
   input  wire logic        req_ready,
   // reply
   input  wire logic        rsp_valid,
   output logic             rsp_ready
);
   int stall = 0;
   int held  = 0;
   initial begin
      req_valid = 1'b0;
      rsp_ready = 1'b0;
      {command_code_field, option_flags_field, block_index_field, byte_offset_field,
       byte_count_field, payload_field, src_endpoint} = '0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // reply taken only after stall cycles, so the handler must hold it
   always @(posedge clk) begin
      held      <= rsp_valid ? held + 1 : 0;
      rsp_ready <= rsp_valid && !rsp_ready && held >= stall;
   end
   task automatic send(input logic [7:0] c, b, o, input logic [15:0] n,
                       input logic [7:0] d, e, output logic ok);
      int k;
      k = 0;
      @(posedge clk);
      req_valid          <= 1'b1;
      command_code_field <= c;
      option_flags_field <= 8'h00;
      block_index_field  <= {8'h00, b};
      byte_offset_field  <= {8'h00, o};
      byte_count_field   <= n;
      payload_field      <= d;
      src_endpoint       <= e;
      // taken at the rising edge that sees req_ready high; release right after it
      do begin @(posedge clk); k++; end while (req_ready !== 1'b1 && k < 100);
      ok = (k < 100);
      req_valid <= 1'b0;
      // released code, block, offset and payload lines show the inverse; count, option and source keep their values
      {command_code_field, block_index_field, byte_offset_field, payload_field} <=
         ~{command_code_field, block_index_field, byte_offset_field, payload_field};
   endtask : send
endmodule : ric_node

// File: tb_remote_image_check_handler.sv
// tb_remote_image_check_handler: self-checking bench for ric_top
// assumes ric_node as requester and default memory of 16 bytes, blocks of 4
`timescale 1ns/100ps
module tb_remote_image_check_handler;
   import ric_pkg::*;
   logic        clk = 1'b0, sys_rst = 1'b1, ok, got;
   logic        req_valid, req_ready, rsp_valid, rsp_ready, image_reset, irq;
   logic [7:0]  command_code_field, option_flags_field, payload_field, src_endpoint;
   logic [15:0] block_index_field, byte_offset_field, byte_count_field;
   logic [7:0]  rsp_command_code, rsp_outcome, rsp_dest_endpoint;
   logic [15:0] rsp_block_index, rsp_byte_offset, rsp_byte_count;
   logic [3:0]  avs_address = 4'h0;
   logic        avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
   int          failures = 0, compares = 0, pulses;
   always #4 clk = ~clk;
   ric_top dut (.clk, .sys_rst, .req_valid, .command_code_field, .option_flags_field,
      .block_index_field, .byte_offset_field, .byte_count_field, .payload_field,
      .src_endpoint, .req_ready, .rsp_valid, .rsp_ready, .rsp_command_code, .rsp_outcome,
      .rsp_block_index, .rsp_byte_offset, .rsp_byte_count, .rsp_dest_endpoint,
      .image_reset, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
      .avs_waitrequest, .irq);
   ric_node node (.clk, .req_valid, .command_code_field, .option_flags_field,
      .block_index_field, .byte_offset_field, .byte_count_field, .payload_field,
      .src_endpoint, .req_ready, .rsp_valid, .rsp_ready);
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string w, input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", w, e, s);
      end
   endtask : chk
   task automatic stop_test();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : stop_test
   // waitrequest and readdata taken at the rising edge that ends the wait
   task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk);
      avs_address   <= a;
      avs_write     <= w;
      avs_read      <= !w;
      avs_writedata <= d;
      do begin @(posedge clk); n++; end while (avs_waitrequest !== 1'b0 && n < 50);
      q = avs_readdata;
      chk("bus answer", n < 50, 1);
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
   endtask : av
   task automatic cmd(input logic [7:0] c, b, o, input logic [15:0] n, input logic [7:0] d, e);
      node.send(c, b, o, n, d, e, ok);
      chk("request taken", ok, 1);
   endtask : cmd
   task automatic reply(input logic [7:0] c, r, e);
      int n;
      n = 0;
      while (rsp_valid !== 1'b1 && n < 8) begin @(negedge clk); n++; end
      chk("reply seen", rsp_valid, 1);
      chk("reply code", rsp_command_code, c);
      chk("outcome", rsp_outcome, r);
      chk("reply fields", {rsp_block_index, rsp_byte_offset, rsp_byte_count}, 0);
      chk("reply dest", rsp_dest_endpoint, e);
      while (rsp_valid === 1'b1 && n < 40) begin @(negedge clk); n++; end
   endtask : reply
   task automatic peek(input logic [7:0] e);
      av(0, RIC_REG_MEMPEEK, 0, rd);
      chk("memory byte 0", rd[7:0], e);
   endtask : peek
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_regs_irq();
      av(0, RIC_REG_MASK, 0, rd);
      chk("mask reset", rd, {29'h0, RIC_MASK_RESET});
      av(1, RIC_REG_MASK, 32'h7, rd);
      av(0, 4'hC, 0, rd);
      chk("unmapped read", rd, 0);
      cmd(RIC_CMD_CHECK, 0, 0, 0, 0, 8'h11);
      reply(RIC_RSP_CHECK, RIC_OUTCOME_BAD, 8'h11);
      repeat (2) @(negedge clk);
      chk("irq raised", irq, 1);
      av(0, RIC_REG_STATUS, 0, rd);
      chk("status check done", rd, 32'h1);
      repeat (2) @(negedge clk);
      chk("irq cleared", irq, 0);
      av(1, 4'hC, 32'h7, rd);
      av(1, RIC_REG_MASK, 32'h0, rd);
      av(0, RIC_REG_MASK, 0, rd);
      chk("mask written", rd, 0);
      cmd(RIC_CMD_CHECK, 0, 0, 0, 0, 8'h12);
      reply(RIC_RSP_CHECK, RIC_OUTCOME_BAD, 8'h12);
      repeat (2) @(negedge clk);
      chk("irq masked", irq, 0);
   endtask : t_regs_irq
   task automatic t_apply_blank();
      node.stall = 3;
      cmd(RIC_CMD_APPLY, 0, 0, 0, 0, 8'hC3);
      reply(RIC_RSP_APPLY, RIC_OUTCOME_BAD, 8'hC3);
      node.stall = 0;
   endtask : t_apply_blank
   task automatic t_erase();
      av(0, RIC_REG_STATUS, 0, rd);
      cmd(RIC_CMD_WRITE, 0, 0, 1, 8'h5A, 8'h01);
      peek(8'h5A);
      cmd(RIC_CMD_WRITE, 0, 0, 1, 8'hF0, 8'h01);
      peek(8'h50);
      cmd(RIC_CMD_ERASE, 0, 1, 4, 0, 8'h01);
      cmd(RIC_CMD_ERASE, 0, 0, 3, 0, 8'h01);
      peek(8'h50);
      av(0, RIC_REG_STATUS, 0, rd);
      chk("erase refused", rd, 32'h4);
      cmd(RIC_CMD_ERASE, 0, 0, 4, 0, 8'h01);
      peek(RIC_ERASED);
   endtask : t_erase
   task automatic t_image();
      cmd(RIC_CMD_WRITE, 0, 0, 1, RIC_IMAGE_TAG, 8'h02);
      // with fourteen bytes still erased the byte sum comes to 00
      cmd(RIC_CMD_WRITE, 0, 1, 1, 8'h69, 8'h02);
      cmd(RIC_CMD_CHECK, 0, 0, 0, 0, 8'h7E);
      reply(RIC_RSP_CHECK, RIC_OUTCOME_GOOD, 8'h7E);
      cmd(RIC_CMD_APPLY, 0, 0, 0, 0, 8'h7E);
      got    = 1'b0;
      pulses = 0;
      repeat (10) begin
         @(negedge clk);
         got    = got | rsp_valid;
         pulses = pulses + (image_reset === 1'b1);
      end
      chk("apply reply", got, 0);
      chk("install pulses", pulses, 1);
      peek(RIC_ERASED);
      cmd(RIC_CMD_CHECK, 0, 0, 0, 0, 8'h7F);
      reply(RIC_RSP_CHECK, RIC_OUTCOME_BAD, 8'h7F);
   endtask : t_image
   initial begin
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      t_regs_irq();
      t_apply_blank();
      t_erase();
      t_image();
      stop_test();
   end
   initial begin
      #200000;
      failures++;
      stop_test();
   end
endmodule : tb_remote_image_check_handler
